// ==== verilog/ccr_pkg.sv ====
package ccr_pkg;

	// ==========================================
	// register addresses in the direct special-function space
	localparam logic [7:0] ADDR_STACK_POINTER = 8'h81;
	localparam logic [7:0] ADDR_DATA_POINTER_LOW = 8'h82;
	localparam logic [7:0] ADDR_DATA_POINTER_HIGH = 8'h83;
	localparam logic [7:0] ADDR_PROCESSOR_FLAGS = 8'hD0;
	localparam logic [7:0] ADDR_ALU_PRIMARY_OPERAND = 8'hE0;
	localparam logic [7:0] ADDR_SECOND_OPERAND = 8'hF0;
	localparam logic [7:0] ADDR_MISC_CONTROL_STROBES = 8'hF8;

	// ==========================================
	// reset values
	localparam logic [7:0] RST_STACK_POINTER = 8'h07;
	localparam logic [7:0] RST_ZERO_BYTE = 8'h00;
	localparam logic [15:0] RST_DATA_POINTER = 16'h0000;

	// ==========================================
	// processor_flags field positions
	localparam int FLAG_CARRY = 7;
	localparam int FLAG_HALF_CARRY = 6;
	localparam int FLAG_USER_ZERO = 5;
	localparam int FLAG_BANK_HIGH = 4;
	localparam int FLAG_BANK_LOW = 3;
	localparam int FLAG_SIGNED_RANGE = 2;
	localparam int FLAG_USER_ONE = 1;
	localparam int FLAG_ONES_ODD = 0;

	// misc_control_strobes: writable bits and pointer select position
	localparam logic [7:0] MISC_WRITABLE_MASK = 8'hF9;
	localparam int MISC_POINTER_SELECT = 0;

	// ==========================================
	// micro-operations issued by the instruction sequencer
	typedef enum logic [4:0] {
		CCR_OP_NONE,
		CCR_OP_ADD,
		CCR_OP_ADDC,
		CCR_OP_SUBB,
		CCR_OP_MUL,
		CCR_OP_DIV,
		CCR_OP_DA,
		CCR_OP_RRC,
		CCR_OP_RLC,
		CCR_OP_SETB_C,
		CCR_OP_CLR_C,
		CCR_OP_CPL_C,
		CCR_OP_ANL_C,
		CCR_OP_ANL_C_NOT,
		CCR_OP_ORL_C,
		CCR_OP_ORL_C_NOT,
		CCR_OP_MOV_C,
		CCR_OP_CJNE,
		CCR_OP_LOAD_ACC,
		CCR_OP_PUSH,
		CCR_OP_POP,
		CCR_OP_CALL,
		CCR_OP_RET
	} ccr_op_t;

	// one request from the sequencer
	typedef struct packed {
		logic valid;
		ccr_op_t op;
		logic [7:0] operand;
		logic bit_in;
	} ccr_req_t;

	// register bus
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ccr_bus_t;

endpackage

// ==== verilog/ccr_muldiv.sv ====
module ccr_muldiv
	import ccr_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	// operands
	input wire logic [WIDTH-1:0] op_a,
	input wire logic [WIDTH-1:0] op_b,
	// results
	output logic [WIDTH-1:0] prod_low,
	output logic [WIDTH-1:0] prod_high,
	output logic prod_wide,
	output logic [WIDTH-1:0] quotient,
	output logic [WIDTH-1:0] remainder,
	output logic div_by_zero
);

	initial
	begin
		if (WIDTH < 1)
			$error("ccr_muldiv: WIDTH must be positive");
	end

	wire [2*WIDTH-1:0] product = {{WIDTH{1'b0}}, op_a} * {{WIDTH{1'b0}}, op_b};

	assign prod_low = product[WIDTH-1:0];
	assign prod_high = product[2*WIDTH-1:WIDTH];
	assign prod_wide = |prod_high;
	assign div_by_zero = (op_b == '0);
	// division by zero leaves both results undefined in the core; hold a
	// fixed pattern so the outcome is at least repeatable
	assign quotient = div_by_zero ? {WIDTH{1'b1}} : op_a / op_b;
	assign remainder = div_by_zero ? op_a : op_a % op_b;

endmodule

// ==== verilog/ccr_bus_slave.sv ====
module ccr_bus_slave
	import ccr_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// bus
	input wire ccr_bus_t bus,
	output logic [7:0] rdata,
	// register view
	input wire logic [7:0] stack_pointer,
	input wire logic [15:0] data_pointer,
	input wire logic [7:0] processor_flags,
	input wire logic [7:0] alu_primary_operand,
	input wire logic [7:0] second_operand_register,
	input wire logic [7:0] misc_control_strobes
);

	logic [7:0] sel_data;

	always_comb
	begin
		unique case (bus.addr)
			ADDR_STACK_POINTER: sel_data = stack_pointer;
			ADDR_DATA_POINTER_LOW: sel_data = data_pointer[7:0];
			ADDR_DATA_POINTER_HIGH: sel_data = data_pointer[15:8];
			ADDR_PROCESSOR_FLAGS: sel_data = processor_flags;
			ADDR_ALU_PRIMARY_OPERAND: sel_data = alu_primary_operand;
			ADDR_SECOND_OPERAND: sel_data = second_operand_register;
			ADDR_MISC_CONTROL_STROBES: sel_data = misc_control_strobes;
			default: sel_data = RST_ZERO_BYTE;
		endcase
	end

	// read data stand in the single cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (srst)
			rdata <= RST_ZERO_BYTE;
		else if (bus.rd)
			rdata <= sel_data;
		else
			rdata <= RST_ZERO_BYTE;
	end

endmodule

// ==== verilog/ccr_core_regs.sv ====
// Overview of operation
// - An 8-bit accumulator at E0h feeds most ALU operations, takes their results, and resets to zero.
// - An 8-bit second operand register at F0h feeds MUL and DIV, is otherwise scratch, and resets to zero.
// - Multiply and divide take their operands only from the accumulator and the second operand register.
// - DIV AB puts the quotient of accumulator over second operand into the accumulator.
// - The stack pointer at 81h addresses internal memory for saving the program counter on calls and restoring it on returns.
// - PUSH increments and POP decrements the stack pointer so it always marks the top of stack.
// - Two 16-bit data pointers share addresses 82h (low) and 83h (high) and both reset to zero.
// - Bit 0 of the control register at F8h chooses the active data pointer used for all pointer accesses.
// - The active data pointer supplies the 16-bit address for external data, offset code fetches and offset jumps.
// - ADD, ADDC and SUBB update carry, half carry and overflow; DA, rotates through carry, CJNE and carry-bit logic update only carry.
// - MUL and DIV clear carry, MUL sets overflow from the high product byte and DIV from a zero divisor, CLR C clears carry, and none touch half carry.
// - SETB C sets carry and leaves overflow and half carry alone.
// - The flags register at D0h holds carry, half carry, user flag, bank select, overflow, user flag and parity from bit 7 down, parity read-only, reset zero.
// - The bank select bits place working registers R0..R7 at 00h, 08h, 10h or 18h of internal RAM.
// - Every cycle hardware sets the parity bit when the accumulator holds an odd count of ones and clears it otherwise.
//
// Added by the designer: strobed register access.
module ccr_core_regs
	import ccr_pkg::*;
#(
	parameter int DATA_WIDTH = 8,
	parameter int POINTER_COUNT = 2
)
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register bus
	input wire ccr_bus_t bus,
	output logic [7:0] bus_rdata,
	// sequencer requests
	input wire ccr_req_t req,
	// addresses and state toward the rest of the core
	output logic [7:0] stack_addr,
	output logic [15:0] pointer_addr,
	output logic [4:0] bank_base,
	output logic [7:0] acc_out,
	output logic [7:0] flags_out,
	output logic [7:0] misc_strobes_out
);

	initial
	begin
		if (DATA_WIDTH != 8)
			$error("ccr_core_regs: only an 8-bit data path is supported");
		if (POINTER_COUNT != 2)
			$error("ccr_core_regs: exactly two data pointers are supported");
		// the bank base below is built from two neighbouring flag bits
		if (FLAG_BANK_HIGH != FLAG_BANK_LOW + 1)
			$error("ccr_core_regs: bank select bits must be adjacent");
		if (MISC_WRITABLE_MASK[MISC_POINTER_SELECT] != 1'b1)
			$error("ccr_core_regs: pointer select bit must be writable");
	end

	// ==========================================
	// state
	logic [7:0] stack_pointer;
	logic [7:0] alu_primary_operand;
	logic [7:0] second_operand_register;
	logic [7:0] processor_flags;
	logic [7:0] misc_control_strobes;
	logic [15:0] data_pointer [POINTER_COUNT];

	// ==========================================
	// next values
	logic [7:0] next_acc;
	logic [7:0] next_second;
	logic [7:0] next_sp;
	logic [7:0] next_flags;

	// ==========================================
	// bus decode
	// an unmapped address matches none of these, so its write is dropped
	wire wr_sp = bus.wr && (bus.addr == ADDR_STACK_POINTER);
	wire wr_dpl = bus.wr && (bus.addr == ADDR_DATA_POINTER_LOW);
	wire wr_dph = bus.wr && (bus.addr == ADDR_DATA_POINTER_HIGH);
	wire wr_flags = bus.wr && (bus.addr == ADDR_PROCESSOR_FLAGS);
	wire wr_acc = bus.wr && (bus.addr == ADDR_ALU_PRIMARY_OPERAND);
	wire wr_second = bus.wr && (bus.addr == ADDR_SECOND_OPERAND);
	wire wr_misc = bus.wr && (bus.addr == ADDR_MISC_CONTROL_STROBES);

	wire pointer_select = misc_control_strobes[MISC_POINTER_SELECT];
	wire [15:0] active_pointer = data_pointer[pointer_select];

	// ==========================================
	// multiply and divide, fed only by the two operand registers
	wire [7:0] md_prod_low;
	wire [7:0] md_prod_high;
	wire md_prod_wide;
	wire [7:0] md_quotient;
	wire [7:0] md_remainder;
	wire md_div_zero;

	ccr_muldiv #(
		.WIDTH(DATA_WIDTH)
	) u_muldiv (
		.op_a(alu_primary_operand),
		.op_b(second_operand_register),
		.prod_low(md_prod_low),
		.prod_high(md_prod_high),
		.prod_wide(md_prod_wide),
		.quotient(md_quotient),
		.remainder(md_remainder),
		.div_by_zero(md_div_zero)
	);

	// ==========================================
	// add and subtract
	wire carry_in = processor_flags[FLAG_CARRY];
	wire is_sub = (req.op == CCR_OP_SUBB);
	wire use_carry = (req.op == CCR_OP_ADDC) || is_sub;
	wire cin = use_carry & carry_in;
	wire [7:0] opnd_eff = is_sub ? ~req.operand : req.operand;
	wire cin_eff = is_sub ? ~cin : cin;
	wire [4:0] low_sum = {1'b0, alu_primary_operand[3:0]} + {1'b0, opnd_eff[3:0]}
		+ {4'h0, cin_eff};
	wire [3:0] mid_sum = {1'b0, alu_primary_operand[6:4]} + {1'b0, opnd_eff[6:4]}
		+ {3'h0, low_sum[4]};
	wire [1:0] top_sum = {1'b0, alu_primary_operand[7]} + {1'b0, opnd_eff[7]}
		+ {1'b0, mid_sum[3]};
	wire [7:0] sum_res = {top_sum[0], mid_sum[2:0], low_sum[3:0]};
	// signed overflow: the carry into the sign bit differs from the carry out of it
	wire carry_into_sign = mid_sum[3];
	wire carry_out_sign = top_sum[1];
	// subtraction reports a borrow, the inverse of the adder carry
	wire sum_cy = is_sub ? ~carry_out_sign : carry_out_sign;
	wire sum_ac = is_sub ? ~low_sum[4] : low_sum[4];
	wire sum_ov = carry_out_sign ^ carry_into_sign;

	// ==========================================
	// decimal adjust: add six to each digit that left the range 0 to 9
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
	localparam logic [8:0] BCD_LOW_ADJUST = 9'h006;
	localparam logic [8:0] BCD_HIGH_ADJUST = 9'h060;
	localparam logic [8:0] BCD_NO_ADJUST = 9'h000;
	wire da_low_fix = (alu_primary_operand[3:0] > BCD_DIGIT_MAX)
		|| processor_flags[FLAG_HALF_CARRY];
	wire [8:0] da_step1 = {1'b0, alu_primary_operand}
		+ (da_low_fix ? BCD_LOW_ADJUST : BCD_NO_ADJUST);
	wire da_high_fix = (da_step1[7:4] > BCD_DIGIT_MAX) || da_step1[8] || carry_in;
	wire [8:0] da_step2 = {1'b0, da_step1[7:0]}
		+ (da_high_fix ? BCD_HIGH_ADJUST : BCD_NO_ADJUST);
	wire da_cy = carry_in | da_step1[8] | da_step2[8];

	// ==========================================
	// accumulator, second operand, flags
	always_comb
	begin
		next_acc = alu_primary_operand;
		next_second = second_operand_register;
		next_flags = processor_flags;
		// carry-only operations leave half carry and overflow as they were
		if (req.valid)
		begin
			unique case (req.op)
				CCR_OP_ADD, CCR_OP_ADDC, CCR_OP_SUBB:
				begin
					next_acc = sum_res;
					next_flags[FLAG_CARRY] = sum_cy;
					next_flags[FLAG_HALF_CARRY] = sum_ac;
					next_flags[FLAG_SIGNED_RANGE] = sum_ov;
				end
				CCR_OP_MUL:
				begin
					next_acc = md_prod_low;
					next_second = md_prod_high;
					next_flags[FLAG_CARRY] = 1'b0;
					next_flags[FLAG_SIGNED_RANGE] = md_prod_wide;
				end
				CCR_OP_DIV:
				begin
					next_acc = md_quotient;
					next_second = md_remainder;
					next_flags[FLAG_CARRY] = 1'b0;
					next_flags[FLAG_SIGNED_RANGE] = md_div_zero;
				end
				CCR_OP_DA:
				begin
					next_acc = da_step2[7:0];
					next_flags[FLAG_CARRY] = da_cy;
				end
				CCR_OP_RRC:
				begin
					next_acc = {carry_in, alu_primary_operand[7:1]};
					next_flags[FLAG_CARRY] = alu_primary_operand[0];
				end
				CCR_OP_RLC:
				begin
					next_acc = {alu_primary_operand[6:0], carry_in};
					next_flags[FLAG_CARRY] = alu_primary_operand[7];
				end
				CCR_OP_SETB_C:
					next_flags[FLAG_CARRY] = 1'b1;
				CCR_OP_CLR_C:
					next_flags[FLAG_CARRY] = 1'b0;
				CCR_OP_CPL_C:
					next_flags[FLAG_CARRY] = ~carry_in;
				CCR_OP_ANL_C:
					next_flags[FLAG_CARRY] = carry_in & req.bit_in;
				CCR_OP_ANL_C_NOT:
					next_flags[FLAG_CARRY] = carry_in & ~req.bit_in;
				CCR_OP_ORL_C:
					next_flags[FLAG_CARRY] = carry_in | req.bit_in;
				CCR_OP_ORL_C_NOT:
					next_flags[FLAG_CARRY] = carry_in | ~req.bit_in;
				CCR_OP_MOV_C:
					next_flags[FLAG_CARRY] = req.bit_in;
				CCR_OP_CJNE:
					// carry is set when the accumulator is below the compare value
					next_flags[FLAG_CARRY] = (alu_primary_operand < req.operand);
				CCR_OP_LOAD_ACC:
					next_acc = req.operand;
				default:
				begin
				end
			endcase
		end
		// a software write lands after the instruction result
		if (wr_acc)
			next_acc = bus.wdata;
		if (wr_second)
			next_second = bus.wdata;
		if (wr_flags)
			next_flags = bus.wdata;
		// parity always tracks the accumulator value being stored
		next_flags[FLAG_ONES_ODD] = ^next_acc;
	end

	// ==========================================
	// stack pointer
	// one step per push, pop, call or return; a call moves the pointer by a single step for the whole program counter
	localparam logic [7:0] STACK_STEP = 8'h01;
	always_comb
	begin
		next_sp = stack_pointer;
		if (req.valid)
		begin
			unique case (req.op)
				CCR_OP_PUSH, CCR_OP_CALL:
					next_sp = stack_pointer + STACK_STEP;
				CCR_OP_POP, CCR_OP_RET:
					next_sp = stack_pointer - STACK_STEP;
				default:
					next_sp = stack_pointer;
			endcase
		end
		// a software write beats a push or pop in the same cycle
		if (wr_sp)
			next_sp = bus.wdata;
	end

	// push and call write at the incremented slot; pop and return read the
	// current top, so the address follows the operation in the same cycle
	wire sp_grows = req.valid && ((req.op == CCR_OP_PUSH) || (req.op == CCR_OP_CALL));
	wire [7:0] next_stack_addr = sp_grows ? next_sp : stack_pointer;

	// ==========================================
	// registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			stack_pointer <= RST_STACK_POINTER;
			alu_primary_operand <= RST_ZERO_BYTE;
			second_operand_register <= RST_ZERO_BYTE;
			processor_flags <= RST_ZERO_BYTE;
			misc_control_strobes <= RST_ZERO_BYTE;
		end
		else
		begin
			stack_pointer <= next_sp;
			alu_primary_operand <= next_acc;
			second_operand_register <= next_second;
			processor_flags <= next_flags;
			// bits 2:1 are not built and always read back as zero
			if (wr_misc)
				misc_control_strobes <= bus.wdata & MISC_WRITABLE_MASK;
		end
	end

	// only the active pointer answers a write at the shared addresses
	generate
		for (genvar i = 0; i < POINTER_COUNT; i++)
		begin : g_ptr
			// the idle pointer keeps its value, so software may park an address in it
			wire is_active = (pointer_select == 1'(i));
			always_ff @(posedge clk)
			begin
				if (srst)
					data_pointer[i] <= RST_DATA_POINTER;
				else if (is_active && wr_dpl)
					data_pointer[i][7:0] <= bus.wdata;
				else if (is_active && wr_dph)
					data_pointer[i][15:8] <= bus.wdata;
			end
		end
	endgenerate

	// ==========================================
	// working register bank base: bank number times eight
	wire [4:0] next_bank_base = {next_flags[FLAG_BANK_HIGH], next_flags[FLAG_BANK_LOW],
		3'b000};

	// ==========================================
	// outputs
	// the external address follows the pointer select one cycle late
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			stack_addr <= RST_ZERO_BYTE;
			pointer_addr <= RST_DATA_POINTER;
			bank_base <= 5'h00;
			acc_out <= RST_ZERO_BYTE;
			flags_out <= RST_ZERO_BYTE;
			misc_strobes_out <= RST_ZERO_BYTE;
		end
		else
		begin
			stack_addr <= next_stack_addr;
			pointer_addr <= active_pointer;
			bank_base <= next_bank_base;
			acc_out <= next_acc;
			flags_out <= next_flags;
			misc_strobes_out <= misc_control_strobes;
		end
	end

	ccr_bus_slave u_bus (
		.clk(clk),
		.srst(srst),
		.bus(bus),
		.rdata(bus_rdata),
		.stack_pointer(stack_pointer),
		.data_pointer(active_pointer),
		.processor_flags(processor_flags),
		.alu_primary_operand(alu_primary_operand),
		.second_operand_register(second_operand_register),
		.misc_control_strobes(misc_control_strobes)
	);

endmodule

// ==== sim/ccr_core_regs_asserts.sv ====
module ccr_core_regs_chk
	import ccr_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register bus
	input wire ccr_bus_t bus,
	input wire logic [7:0] bus_rdata,
	// sequencer
	input wire ccr_req_t req,
	// state toward the core
	input wire logic [7:0] stack_addr,
	input wire logic [15:0] pointer_addr,
	input wire logic [4:0] bank_base,
	input wire logic [7:0] acc_out,
	input wire logic [7:0] flags_out,
	input wire logic [7:0] misc_strobes_out
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	// a bus write in the same cycle overrides an op result, so leave those cycles out
	wire op_ok = req.valid && !bus.wr;

	sequence s_push;
		op_ok && req.op == CCR_OP_PUSH;
	endsequence
	sequence s_push_pair;
		s_push ##1 s_push;
	endsequence

	a_parity_odd: assert property (flags_out[0] == ^acc_out)
		else $error("parity bit disagrees with accumulator");
	a_bank_map: assert property (bank_base == {flags_out[4:3], 3'b000})
		else $error("bank base does not follow bank select");
	a_setb_sets: assert property ((op_ok && req.op == CCR_OP_SETB_C) |=>
		flags_out[7] && $stable(flags_out[6]) && $stable(flags_out[2]))
		else $error("set carry wrong or touched other flags");
	a_clr_clears: assert property ((op_ok && req.op == CCR_OP_CLR_C) |=>
		!flags_out[7] && $stable(flags_out[6]))
		else $error("clear carry wrong");
	a_muldiv_flags: assert property ((op_ok && req.op inside {CCR_OP_MUL, CCR_OP_DIV}) |=>
		!flags_out[7] && $stable(flags_out[6]))
		else $error("multiply or divide left carry or half carry wrong");
	a_push_step: assert property (s_push_pair |=> stack_addr == 8'($past(stack_addr) + 1))
		else $error("stack pointer did not step up on push");
	a_load_acc: assert property ((op_ok && req.op == CCR_OP_LOAD_ACC) |=>
		acc_out == $past(req.operand))
		else $error("accumulator load lost");
	a_read_acc: assert property ((bus.rd && bus.addr == ADDR_ALU_PRIMARY_OPERAND && !req.valid)
		|=> bus_rdata == $past(acc_out))
		else $error("accumulator read returned wrong data");
	a_misc_delay: assert property ((bus.wr && bus.addr == ADDR_MISC_CONTROL_STROBES) |->
		##2 misc_strobes_out == ($past(bus.wdata, 2) & MISC_WRITABLE_MASK))
		else $error("control strobes output wrong");
endmodule

// ==== sim/tb_ccr_core_regs.sv ====
module tb_ccr_core_regs
	import ccr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic srst = 1'b1;
	ccr_bus_t bus = '0;
	ccr_req_t req = '0;
	logic [7:0] bus_rdata, stack_addr, acc_out, flags_out, misc_strobes_out;
	logic [15:0] pointer_addr;
	logic [4:0] bank_base;
	int failures = 0;
	int num_checks = 0;
	logic [7:0] ra[7] = '{8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0, 8'hF0, 8'hF8};
	logic [7:0] rv[7] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	// pointer 1 is active after the F8 write, and parity is never writable
	logic [7:0] wv[7] = '{8'hA5, 8'h00, 8'h00, 8'hA4, 8'hA5, 8'hA5, 8'hA1};
	// ==========================================
	// op table: {operand, expected acc} and {bit_in, carry, half carry, overflow}
	ccr_op_t t_op[19] = '{CCR_OP_LOAD_ACC, CCR_OP_ADD, CCR_OP_ADDC, CCR_OP_SUBB,
		CCR_OP_SETB_C, CCR_OP_CPL_C, CCR_OP_ORL_C, CCR_OP_ANL_C, CCR_OP_ORL_C_NOT,
		CCR_OP_ANL_C_NOT, CCR_OP_MOV_C, CCR_OP_CLR_C, CCR_OP_CJNE, CCR_OP_CJNE,
		CCR_OP_RRC, CCR_OP_RLC, CCR_OP_DA, CCR_OP_MUL, CCR_OP_DIV};
	logic [15:0] t_x[19] = '{16'h7878, 16'h8800, 16'h7F80, 16'h017F, 16'h007F, 16'h007F,
		16'h007F, 16'h007F, 16'h007F, 16'h007F, 16'h007F, 16'h007F, 16'h807F, 16'h107F,
		16'h003F, 16'h007F, 16'h0085, 16'h00B9, 16'h0002};
	logic [3:0] t_f[19] = '{4'h0, 4'h6, 4'h3, 4'h3, 4'h7, 4'h3, 4'hF, 4'h3, 4'h7,
		4'hB, 4'hF, 4'h3, 4'h7, 4'h3, 4'h7, 4'h3, 4'h3, 4'h3, 4'h2};

	always #12.5 clk = ~clk;

	ccr_core_regs dut (.clk(clk), .srst(srst), .bus(bus), .bus_rdata(bus_rdata), .req(req),
		.stack_addr(stack_addr), .pointer_addr(pointer_addr), .bank_base(bank_base),
		.acc_out(acc_out), .flags_out(flags_out), .misc_strobes_out(misc_strobes_out));

	// ==========================================
	// access tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 chk(16'(bus_rdata), 16'(exp));
	endtask
	// op holds the request so two calls give back-to-back ops; op_end releases it
	task automatic op(input ccr_op_t o, input logic [7:0] x, input logic b);
		@(posedge clk);
		req <= '{1'b1, o, x, b};
	endtask
	task automatic op_end;
		@(posedge clk);
		req <= '0;
		#1;
	endtask
	task automatic give_verdict;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==========================================
	// main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		foreach (ra[i])
			rd(ra[i], rv[i]);
		foreach (ra[i])
			wr(ra[i], 8'hA5);
		foreach (ra[i])
			rd(ra[i], wv[i]);
		wr(8'h90, 8'h5A);
		rd(8'h90, 8'h00);
		wr(ADDR_DATA_POINTER_LOW, 8'hCD);
		wr(ADDR_DATA_POINTER_HIGH, 8'hAB);
		@(posedge clk);
		#1 chk(pointer_addr, 16'hABCD);
		wr(ADDR_MISC_CONTROL_STROBES, 8'h00);
		rd(ADDR_DATA_POINTER_LOW, 8'hA5);
		rd(ADDR_DATA_POINTER_HIGH, 8'hA5);
		chk(pointer_addr, 16'hA5A5);
		for (int b = 0; b < 4; b++)
		begin
			wr(ADDR_PROCESSOR_FLAGS, 8'(b << 3));
			#1 chk(16'(bank_base), 16'(b << 3));
		end
		foreach (t_op[i])
		begin
			op(t_op[i], t_x[i][15:8], t_f[i][3]);
			op_end();
			chk(16'(acc_out), 16'(t_x[i][7:0]));
			chk(16'({flags_out[7:6], flags_out[2]}), 16'(t_f[i][2:0]));
		end
		rd(ADDR_SECOND_OPERAND, 8'h0F);
		op(CCR_OP_PUSH, 8'h00, 1'b0);
		op(CCR_OP_PUSH, 8'h00, 1'b0);
		op_end();
		chk(16'(stack_addr), 16'h00A7);
		op(CCR_OP_POP, 8'h00, 1'b0);
		op_end();
		chk(16'(stack_addr), 16'h00A7);
		rd(ADDR_STACK_POINTER, 8'hA6);
		op(CCR_OP_CALL, 8'h00, 1'b0);
		op_end();
		chk(16'(stack_addr), 16'h00A7);
		op(CCR_OP_RET, 8'h00, 1'b0);
		op_end();
		chk(16'(stack_addr), 16'h00A7);
		rd(ADDR_STACK_POINTER, 8'hA6);
		// divide by zero: quotient all ones, remainder the old accumulator, overflow set
		wr(ADDR_SECOND_OPERAND, 8'h00);
		op(CCR_OP_DIV, 8'h00, 1'b0);
		op_end();
		chk(16'(acc_out), 16'h00FF);
		chk(16'({flags_out[7:6], flags_out[2]}), 16'h0003);
		rd(ADDR_SECOND_OPERAND, 8'h02);
		// a bus write in the same cycle as an instruction result wins
		@(posedge clk);
		req <= '{1'b1, CCR_OP_LOAD_ACC, 8'h11, 1'b0};
		bus <= '{ADDR_ALU_PRIMARY_OPERAND, 8'h22, 1'b1, 1'b0};
		@(posedge clk);
		req <= '0;
		bus <= '0;
		#1 chk(16'(acc_out), 16'h0022);
		wr(ADDR_MISC_CONTROL_STROBES, 8'hFE);
		@(posedge clk);
		#1 chk(16'(misc_strobes_out), 16'h00F8);
		give_verdict();
	end

	// the whole run needs about 135 cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("unexpected at %0t: watchdog expired", $time);
		give_verdict();
	end
endmodule

bind ccr_core_regs ccr_core_regs_chk u_chk (.clk(clk), .srst(srst), .bus(bus),
	.bus_rdata(bus_rdata), .req(req), .stack_addr(stack_addr), .pointer_addr(pointer_addr),
	.bank_base(bank_base), .acc_out(acc_out), .flags_out(flags_out),
	.misc_strobes_out(misc_strobes_out));
